// ==== verilog/led_dim_regs.v ====
// LED5 to LED9 brightness control: APB slave, channel registers, shared
// dimming time base and a PWM output plus its inverse switch drive per LED.
// Assumes an APB master on pclk; all outputs come from flip-flops.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.vh"

module led_dim_regs #(
	parameter STEP_DIV = 1
) (
	// clock and reset
	input  wire                  pclk,
	input  wire                  presetn,
	// apb slave
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [11:0]           paddr,
	input  wire [31:0]           pwdata,
	output reg  [31:0]           prdata,
	output reg                   pready,
	output reg                   pslverr,
	// led drive, bit 0 is LED5
	output wire [`CH_COUNT-1:0]  led_on,
	output wire [`CH_COUNT-1:0]  switch_on,
	// time base
	output wire                  period_start
);

	localparam [9:0] CH_BASE  = {2'b00, `LED5_IDX};
	localparam [9:0] CTRL_AD  = {2'b00, `CTRL_IDX};
	localparam [9:0] STAT_AD  = {2'b00, `STAT_IDX};
	localparam integer CH_NUM = `CH_COUNT;

	wire [9:0]                      idx;
	wire [9:0]                      rel;
	wire                            aligned;
	wire                            ch_hit;
	wire                            ctrl_hit;
	wire                            stat_hit;
	wire                            hit;
	wire                            setup;
	wire                            wr_fire;
	wire [2:0]                      ch_sel;
	wire [`CH_COUNT*`CH_REG_W-1:0]  cfg_all;
	wire [`STEP_W-1:0]              step_cnt;
	reg                             run_q;
	reg                             imm_q;
	reg                             restart_q;
	reg  [31:0]                     rd_d;
	integer                         i;

	// ================================================================
	// address decode; LED5 sits one index below LED6
	assign idx      = paddr[11:2];
	assign aligned  = (paddr[1:0] == 2'b00);
	assign rel      = idx - CH_BASE;
	assign ch_hit   = aligned && (idx >= CH_BASE) &&
		({{22{1'b0}}, rel} < CH_NUM);
	assign ctrl_hit = aligned && (idx == CTRL_AD);
	assign stat_hit = aligned && (idx == STAT_AD);
	assign hit      = ch_hit || ctrl_hit || stat_hit;
	assign ch_sel   = rel[2:0];

	assign setup    = psel && !penable;
	// one fixed wait-free access: pready rises in the access cycle
	assign wr_fire  = psel && penable && pready && pwrite;

	// ================================================================
	// read mux
	always @* begin
		rd_d = 32'h00000000;
		if (ch_hit) begin
			for (i = 0; i < `CH_COUNT; i = i + 1) begin
				if (ch_sel == i[2:0]) begin
					rd_d[`CH_REG_W-1:0] = cfg_all[i*`CH_REG_W +: `CH_REG_W];
				end
			end
		end else if (ctrl_hit) begin
			rd_d[`CTRL_RUN_BIT] = run_q;
			rd_d[`CTRL_IMM_BIT] = imm_q;
		end else if (stat_hit) begin
			rd_d[`STAT_CNT_LSB +: `STEP_W]    = step_cnt;
			rd_d[`STAT_LED_LSB +: `CH_COUNT]  = led_on;
			rd_d[`STAT_RUN_BIT]               = run_q;
		end
	end

	// ================================================================
	// apb answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= !hit;
			prdata  <= pwrite ? 32'h00000000 : rd_d;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

	// ================================================================
	// control register; restart is a write-one pulse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q     <= `CTRL_RUN_RST;
			imm_q     <= `CTRL_IMM_RST;
			restart_q <= 1'b0;
		end else if (wr_fire && ctrl_hit) begin
			run_q     <= pwdata[`CTRL_RUN_BIT];
			imm_q     <= pwdata[`CTRL_IMM_BIT];
			restart_q <= pwdata[`CTRL_RESTART_BIT];
		end else begin
			restart_q <= 1'b0;
		end
	end

	// ================================================================
	// time base and channels
	dim_timebase #(
		.STEP_DIV       (STEP_DIV)
	) u_timebase (
		.pclk           (pclk),
		.presetn        (presetn),
		.run            (run_q),
		.restart        (restart_q),
		.step_cnt_q     (step_cnt),
		.period_start_q (period_start)
	);

	genvar g;
	generate
		for (g = 0; g < `CH_COUNT; g = g + 1) begin : g_ch
			dim_channel u_ch (
				.pclk         (pclk),
				.presetn      (presetn),
				.wr_en        (wr_fire && ch_hit && (ch_sel == g)),
				.wr_data      (pwdata[`CH_REG_W-1:0]),
				.load_now     (imm_q),
				.period_start (period_start),
				.step_cnt     (step_cnt),
				.cfg_q        (cfg_all[g*`CH_REG_W +: `CH_REG_W]),
				.led_q        (led_on[g]),
				.switch_q     (switch_on[g])
			);
		end
	endgenerate

endmodule // led_dim_regs

`default_nettype wire

// ==== verilog/led_dim_defines.vh ====
// Constants for the LED brightness control block: register indices,
// field positions, reset values and the dimming period length.
// Assumes the includer wraps registers as one aligned 32-bit APB word each.
//
// Overview of operation
// - 12-bit duty in 11:0, control bit 12
// - duty zero keeps LED off all period
// - each duty step adds one 1/4095 on-step
// - duty all ones keeps LED fully on
// - bit 12 zero dims, one disables dimming
// - LED6 to LED9 at consecutive indices
// - all fields writable, read returns last write
// - reset clears duty and control bit
// - LED5 sits just below LED6, same layout
`ifndef LED_DIM_DEFINES_VH
`define LED_DIM_DEFINES_VH

// ================================================================
// register indices (byte address is four times the index)
`define LED5_IDX        8'h46
`define LED6_IDX        8'h47
`define LED7_IDX        8'h48
`define LED8_IDX        8'h49
`define LED9_IDX        8'h4A
`define CTRL_IDX        8'h50
`define STAT_IDX        8'h51
`define CH_COUNT        5

// ================================================================
// channel register layout
`define DUTY_MSB        11
`define DUTY_LSB        0
`define DIMOFF_BIT      12
`define CH_REG_W        13
`define CH_REG_RST      13'h0000

// ================================================================
// control and status layout
`define CTRL_RUN_BIT    0
`define CTRL_IMM_BIT    1
`define CTRL_RESTART_BIT 2
`define CTRL_RUN_RST    1'b1
`define CTRL_IMM_RST    1'b0
`define STAT_CNT_LSB    0
`define STAT_LED_LSB    16
`define STAT_RUN_BIT    24

// ================================================================
// dimming period: counter runs 0 .. 4094, 4095 steps
`define STEP_LAST       12'hFFE
`define STEP_W          12

`endif

// ==== verilog/dim_timebase.v ====
// Shared dimming time base: a step divider and the period step counter.
// Assumes a single clock; the step rate is an enable pulse from the divider.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.vh"

module dim_timebase #(
	parameter STEP_DIV = 1
) (
	// clock and reset
	input  wire                 pclk,
	input  wire                 presetn,
	// control
	input  wire                 run,
	input  wire                 restart,
	// time base out
	output reg  [`STEP_W-1:0]   step_cnt_q,
	output reg                  period_start_q
);

	localparam DIV_W = 16;
	// kept as an integer so the compare below is 32 bits on both sides
	localparam integer DIV_LAST = STEP_DIV - 1;

	reg  [DIV_W-1:0] div_q;
	wire             step_en;

	// ================================================================
	// step divider
	assign step_en = run && ({{(32-DIV_W){1'b0}}, div_q} == DIV_LAST);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= {DIV_W{1'b0}};
		end else if (restart || !run || step_en) begin
			div_q <= {DIV_W{1'b0}};
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// ================================================================
	// period counter, 4095 steps per period
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt_q     <= {`STEP_W{1'b0}};
			period_start_q <= 1'b1;
		end else if (restart) begin
			step_cnt_q     <= {`STEP_W{1'b0}};
			period_start_q <= 1'b1;
		end else if (step_en) begin
			if (step_cnt_q == `STEP_LAST) begin
				step_cnt_q     <= {`STEP_W{1'b0}};
				period_start_q <= 1'b1;
			end else begin
				step_cnt_q     <= step_cnt_q + 1'b1;
				period_start_q <= 1'b0;
			end
		end else begin
			period_start_q <= 1'b0;
		end
	end

endmodule // dim_timebase

`default_nettype wire

// ==== verilog/dim_channel.v ====
// One LED channel: its control register, the active compare value and
// the registered PWM output. Assumes the shared counter from dim_timebase.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.vh"

module dim_channel (
	// clock and reset
	input  wire                  pclk,
	input  wire                  presetn,
	// register write
	input  wire                  wr_en,
	input  wire [`CH_REG_W-1:0]  wr_data,
	// time base
	input  wire                  load_now,
	input  wire                  period_start,
	input  wire [`STEP_W-1:0]    step_cnt,
	// outputs
	output reg  [`CH_REG_W-1:0]  cfg_q,
	output reg                   led_q,
	output reg                   switch_q
);

	reg  [`CH_REG_W-1:0] active_q;
	wire [`STEP_W-1:0]   duty;
	wire                 dim_off;
	reg                  led_d;

	// ================================================================
	// software register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `CH_REG_RST;
		end else if (wr_en) begin
			cfg_q <= wr_data;
		end
	end

	// new settings take over after the first clock of step 0 of a period, so that
	// clock still sees the old compare value, unless immediate loading is chosen
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_q <= `CH_REG_RST;
		end else if (period_start || load_now) begin
			active_q <= cfg_q;
		end
	end

	assign duty    = active_q[`DUTY_MSB:`DUTY_LSB];
	assign dim_off = active_q[`DIMOFF_BIT];

	// ================================================================
	// compare; counter tops at 4094 so all ones is on every step
	always @* begin
		led_d = 1'b0;
		if (dim_off) begin
			led_d = (duty != {`STEP_W{1'b0}});
		end else begin
			led_d = (step_cnt < duty);
		end
	end

	// the bypass switch shorts the LED, so it is the inverse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_q    <= 1'b0;
			switch_q <= 1'b1;
		end else begin
			led_q    <= led_d;
			switch_q <= ~led_d;
		end
	end

endmodule // dim_channel

`default_nettype wire

// ==== tb/led_dim_monitor.sv ====
// Port-level checker for the LED dimming register block.
// Assumes the top module led_dim_regs on pclk with zero-wait APB.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.vh"

module led_dim_monitor #(
	parameter STEP_DIV = 1
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic [`CH_COUNT-1:0] led_on,
	input wire logic [`CH_COUNT-1:0] switch_on,
	input wire logic                 period_start
);
	logic ch_hit;

	// ================================================================
	// apb and drive checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign ch_hit = paddr >= 12'h118 && paddr <= 12'h128 && paddr[1:0] == 2'h0;

	a_ready_follows: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	a_switch_inv: assert property (switch_on == ~led_on)
		else $error("switch drive not inverse of led");
	a_chan_ok: assert property (pready && ch_hit |-> !pslverr)
		else $error("channel access refused");
	a_misalign_err: assert property (pready && paddr[1:0] != 2'h0
		|-> pslverr && prdata == 32'h0)
		else $error("misaligned access accepted");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_chan_upper: assert property (pready && ch_hit && !pwrite
		|-> prdata[31:13] == 19'h0)
		else $error("channel upper bits not zero");
	a_period_pulse: assert property ($rose(period_start)
		|=> !period_start [*8])
		else $error("period start too close");
endmodule // led_dim_monitor

bind led_dim_regs led_dim_monitor #(.STEP_DIV(STEP_DIV)) u_led_dim_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .led_on(led_on),
	.switch_on(switch_on), .period_start(period_start));
`default_nettype wire

// ==== tb/test_led_dim_regs.sv ====
// Self-checking bench for the LED dimming register block.
// Assumes led_dim_regs with STEP_DIV 1, so one period is 4095 clocks.
`timescale 1ns/100ps
`default_nettype none
`include "led_dim_defines.vh"

module test_led_dim_regs;
	localparam logic [12:0] VAL [6] = '{13'h0, 13'h1, 13'h2, 13'hFFF,
		13'h1005, 13'h1000};
	localparam int EXP [6] = '{0, 1, 2, 4095, 4095, 0};
	logic                 pclk, presetn, psel, penable, pwrite;
	logic                 pready, pslverr, period_start, er;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic [`CH_COUNT-1:0] led_on, switch_on;
	int                   error_cnt = 0;
	int                   samples_checked = 0;

	led_dim_regs #(.STEP_DIV(1)) u_led_dim_regs (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .led_on(led_on), .switch_on(switch_on),
		.period_start(period_start));

	// ================================================================
	// helpers
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	// waits for pready however long it takes; only the watchdog ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ================================================================
	// scenarios
	task t_reset;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'h118 + 12'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		chk({27'h0, switch_on}, 32'h1F);
		$display("reset test done");
	endtask

	task t_regs;
		for (int i = 0; i < 5; i++)
			apb(1'b1, 12'h118 + 12'(4 * i), 32'hFFFF_E000 | 32'(4369 * (i + 1)));
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'h118 + 12'(4 * i), 32'h0);
			chk(rd, 32'(4369 * (i + 1)) & 32'h1FFF);
		end
		apb(1'b0, 12'h11A, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("register test done");
	endtask

	task t_duty;
		int n;
		// immediate load so each new duty is seen without a period wait
		apb(1'b1, 12'h140, 32'h3);
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, 12'h118 + 12'(4 * (k % 5)), {19'h0, VAL[k]});
			repeat (3) @(posedge pclk);
			n = 0;
			repeat (4095) begin
				@(posedge pclk);
				if (led_on[k % 5] === 1'b1)
					n++;
				else if (led_on[k % 5] !== 1'b0)
					n += 8192;
			end
			chk(n, EXP[k]);
		end
		$display("duty test done");
	endtask

	// stop and restart the time base: the counter parks at step 0, where
	// the duties left by the duty test give LED6..LED9 lit and LED5 dark
	task t_ctrl;
		apb(1'b1, 12'h140, 32'h4);
		repeat (2) @(posedge pclk);
		apb(1'b0, 12'h144, 32'h0);
		chk(rd, 32'h001E_0000);
		chk({27'h0, led_on}, 32'h1E);
		chk({27'h0, switch_on}, 32'h01);
		apb(1'b0, 12'h140, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h140, 32'h1);
		$display("control test done");
	endtask

	// ================================================================
	// main sequence and watchdog
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		t_duty;
		t_ctrl;
		final_report;
	end

	initial begin
		#(50 * 40000);
		error_cnt++;
		final_report;
	end
endmodule // test_led_dim_regs
`default_nettype wire
